// File: design/sram_ctrl.sv
// Controller that drives an asynchronous 2M x 8 static RAM through its pins.
// Assumes the memory pins are sampled synchronously to CLK and the board adds no skew
// beyond one clock period; timing counts default to the 10 ns speed grade.
`include "sram_ctrl_regs.svh"

// How it works
// - Address is driven one cycle before the select falls on a read.
// - A write happens only while select, a lane enable and strobe are low.
// - Select and strobe go valid together, a cycle after the lanes; raising strobe and select ends it.
// - Write data is driven before the strobe and held past its end.
// - Address stands long enough before the write ends.
// - Address does not change until a cycle after the write ends.
// - Strobe stays low at least the width required with gate low.
// - Strobe low time also covers memory float delay plus data lead.
// - Data pins are only driven once the memory has floated them.
// - Deselect means primary select high and secondary select low together.
// - During retention every other pin is held at a rail level.
module sram_ctrl #(
    parameter int unsigned ACCESS_CYC  = `CYCLES_UP(`ADDRESS_TO_DATA_DELAY_PS),
    parameter int unsigned FLOAT_CYC   = `CYCLES_UP(`MAX2(`GATE_OFF_FLOAT_DELAY_PS, `DESELECT_FLOAT_DELAY_PS)),
    parameter int unsigned RC_CYC      = `CYCLES_UP(`READ_CYCLE_MIN_PS),
    parameter int unsigned PULSE_CYC   = `CYCLES_UP(`MAX2(`MAX2(`STROBE_WIDTH_GATE_LOW_PS, `ADDR_TO_WRITE_END_PS),
                                          `STROBE_LOW_FLOAT_DELAY_PS + `WDATA_LEAD_BEFORE_END_PS))
) (
    input  wire logic               CLK,
    input  wire logic               RST_N,
    input  wire logic               CE,
    // User request side
    input  wire logic               REQ_VALID,
    output logic                    REQ_READY,
    input  wire logic               REQ_WRITE,
    input  wire logic [`ADDR_W-1:0] REQ_ADDR,
    input  wire logic [`DATA_W-1:0] REQ_WDATA,
    input  wire logic [`LANE_W-1:0] REQ_LANES_N,
    output logic                    RSP_VALID,
    output logic [`DATA_W-1:0]      RSP_RDATA,
    input  wire logic               RETAIN,
    output logic                    RETAINING,
    // Memory pins
    output logic [`ADDR_W-1:0]      MEM_ADDR,
    output logic                    PRIMARY_SELECT_N,
    output logic                    SECONDARY_SELECT_HIGH,
    output logic                    WRITE_STROBE_N,
    output logic                    OUTPUT_GATE_N,
    output logic                    UPPER_LANE_ENABLE_N,
    output logic                    LOWER_LANE_ENABLE_N,
    input  wire logic [`DATA_W-1:0] DQ_IN,
    output logic [`DATA_W-1:0]      DQ_OUT,
    output logic                    DQ_OE
);
    sram_ctrl_pkg::ctrl_s s_q;
    sram_ctrl_pkg::ctrl_s s_d;
    logic                 cnt_load;
    logic [`CNT_W-1:0]    cnt_val;
    logic                 cnt_zero;

    // Counter load values; each timed phase ends on the edge after the counter reads zero,
    // so a load of N holds the pins for N+1 cycles
    localparam logic [`CNT_W-1:0] ACCESS_LD  = `CNT_W'(ACCESS_CYC);
    localparam logic [`CNT_W-1:0] RECOVER_LD = `CNT_W'(`MAX2(FLOAT_CYC, RC_CYC));
    localparam logic [`CNT_W-1:0] PULSE_LD   = `CNT_W'(PULSE_CYC - 1);
    localparam logic [`CNT_W-1:0] RETAIN_LD  = `CNT_W'(RC_CYC);

    // Pin levels that leave the memory deselected and its data pins free
    function automatic sram_ctrl_pkg::ctrl_s park(input sram_ctrl_pkg::ctrl_s s);
        sram_ctrl_pkg::ctrl_s r;
        r          = s;
        r.sel_n    = `SEL_N_IDLE;
        r.sel_h    = `SEL_H_IDLE;
        r.strobe_n = `STROBE_N_IDLE;
        r.gate_n   = 1'h1;
        r.lanes_n  = `LANES_N_IDLE;
        r.dq_oe    = 1'h0;
        return r;
    endfunction : park

    delay_count u_delay (
        .CLK      (CLK),
        .RST_N    (RST_N),
        .CE       (CE),
        .load     (cnt_load),
        .load_val (cnt_val),
        .zero     (cnt_zero)
    );

    // Next-state logic for the whole pin sequencer
    always_comb begin
        s_d           = s_q;
        s_d.rsp_valid = 1'h0;
        cnt_load      = 1'h0;
        cnt_val       = '0;
        case (s_q.st)
            sram_ctrl_pkg::ST_IDLE: begin
                if (REQ_VALID && s_q.ready) begin
                    s_d.addr = REQ_ADDR;
                    if (REQ_WRITE) begin
                        // Gate has been high since the last read recovered, so the
                        // memory no longer drives; safe to drive data now
                        s_d.wdata   = REQ_WDATA;
                        s_d.lanes_n = REQ_LANES_N;
                        s_d.dq_oe   = 1'h1;
                        s_d.st      = sram_ctrl_pkg::ST_WR_SETUP;
                    end else begin
                        s_d.st = sram_ctrl_pkg::ST_RD_SETUP;
                    end
                end else if (RETAIN) begin
                    // A pending request wins; retention only starts from a quiet idle
                    // Deselected, address and data parked low, strobe, gate and lanes high
                    s_d       = park(s_q);
                    s_d.addr  = '0;
                    s_d.wdata = '0;
                    s_d.dq_oe = 1'h1;
                    s_d.st    = sram_ctrl_pkg::ST_RETAIN;
                end
            end
            sram_ctrl_pkg::ST_RD_SETUP: begin
                // Address has stood one cycle; now select, gate and lanes go low
                s_d.sel_n   = 1'h0;
                s_d.sel_h   = 1'h1;
                s_d.gate_n  = 1'h0;
                s_d.lanes_n = `LANES_N_ALL;
                cnt_load    = 1'h1;
                cnt_val     = ACCESS_LD;
                s_d.st      = sram_ctrl_pkg::ST_RD_ACCESS;
            end
            sram_ctrl_pkg::ST_RD_ACCESS: begin
                // Sampling a cycle late costs latency but leaves margin on the access time
                if (cnt_zero) begin
                    s_d           = park(s_q);
                    s_d.rdata     = DQ_IN;
                    s_d.rsp_valid = 1'h1;
                    cnt_load      = 1'h1;
                    cnt_val       = RECOVER_LD;
                    s_d.st        = sram_ctrl_pkg::ST_RECOVER;
                end
            end
            sram_ctrl_pkg::ST_RECOVER: begin
                // Covers the float time and the read cycle time, whichever is longer
                if (cnt_zero) begin
                    s_d.st = sram_ctrl_pkg::ST_IDLE;
                end
            end
            sram_ctrl_pkg::ST_WR_SETUP: begin
                // Select and strobe fall together, a cycle after the lanes; the gate stays high for the write
                s_d.sel_n    = 1'h0;
                s_d.sel_h    = 1'h1;
                s_d.strobe_n = 1'h0;
                cnt_load     = 1'h1;
                cnt_val      = PULSE_LD;
                s_d.st       = sram_ctrl_pkg::ST_WR_PULSE;
            end
            sram_ctrl_pkg::ST_WR_PULSE: begin
                if (cnt_zero) begin
                    // Strobe and select rise together; address and data stay
                    s_d.strobe_n = `STROBE_N_IDLE;
                    s_d.sel_n    = `SEL_N_IDLE;
                    s_d.sel_h    = `SEL_H_IDLE;
                    s_d.st       = sram_ctrl_pkg::ST_WR_END;
                end
            end
            sram_ctrl_pkg::ST_WR_END: begin
                // One cycle of hold on address and data after the end
                s_d    = park(s_q);
                s_d.st = sram_ctrl_pkg::ST_IDLE;
            end
            sram_ctrl_pkg::ST_RETAIN: begin
                if (!RETAIN) begin
                    s_d.dq_oe = 1'h0;
                    cnt_load  = 1'h1;
                    cnt_val   = RETAIN_LD;
                    s_d.st    = sram_ctrl_pkg::ST_RECOVER;
                end
            end
            default: begin
                s_d    = park(s_q);
                s_d.st = sram_ctrl_pkg::ST_IDLE;
            end
        endcase
        // Ready is a flop so the user sees it only in a settled idle state
        s_d.ready = (s_d.st == sram_ctrl_pkg::ST_IDLE) && !(REQ_VALID && s_q.ready);
        // Retention flag is a flop of its own so the output is not a state decode
        s_d.retaining = (s_d.st == sram_ctrl_pkg::ST_RETAIN);
    end

    // State register; clock enable freezes everything
    // Reset levels match park(), so the memory starts deselected with its pins free
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s_q          <= '0;
            s_q.st       <= sram_ctrl_pkg::ST_IDLE;
            s_q.sel_n    <= `SEL_N_IDLE;
            s_q.sel_h    <= `SEL_H_IDLE;
            s_q.strobe_n <= `STROBE_N_IDLE;
            s_q.gate_n   <= 1'h1;
            s_q.lanes_n  <= `LANES_N_IDLE;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    // Every output is a field of the state register
    assign REQ_READY             = s_q.ready;
    assign RSP_VALID             = s_q.rsp_valid;
    assign RSP_RDATA             = s_q.rdata;
    assign RETAINING             = s_q.retaining;
    assign MEM_ADDR              = s_q.addr;
    assign PRIMARY_SELECT_N      = s_q.sel_n;
    assign SECONDARY_SELECT_HIGH = s_q.sel_h;
    assign WRITE_STROBE_N        = s_q.strobe_n;
    assign OUTPUT_GATE_N         = s_q.gate_n;
    assign UPPER_LANE_ENABLE_N   = s_q.lanes_n[1];
    assign LOWER_LANE_ENABLE_N   = s_q.lanes_n[0];
    assign DQ_OUT                = s_q.wdata;
    assign DQ_OE                 = s_q.dq_oe;

endmodule : sram_ctrl

// File: include/sram_ctrl_regs.svh
// Timing figures and field widths for the asynchronous SRAM controller.
// Assumes a single 250 MHz clock; figures are in picoseconds for the 10 ns speed grade.
`ifndef SRAM_CTRL_REGS_SVH
`define SRAM_CTRL_REGS_SVH

`define CLK_PERIOD_PS              4000
`define ADDR_W                     21
`define DATA_W                     8
`define LANE_W                     2
`define CNT_W                      4
`define STATE_W                    4

// Pin timing of the memory, picoseconds
`define READ_CYCLE_MIN_PS          10000
`define ADDRESS_TO_DATA_DELAY_PS   10000
`define GATE_OFF_FLOAT_DELAY_PS    5000
`define DESELECT_FLOAT_DELAY_PS    5000
`define ADDR_TO_WRITE_END_PS       8000
`define WDATA_LEAD_BEFORE_END_PS   6000
`define STROBE_WIDTH_GATE_LOW_PS   10000
`define STROBE_LOW_FLOAT_DELAY_PS  4000

// Least times round up to whole cycles
`define CYCLES_UP(ps)   (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define MAX2(a, b)      (((a) > (b)) ? (a) : (b))

// Pin idle levels, and the lane level that enables both lanes
`define SEL_N_IDLE      1'h1
`define SEL_H_IDLE      1'h0
`define STROBE_N_IDLE   1'h1
`define LANES_N_IDLE    2'h3
`define LANES_N_ALL     2'h0

`endif

// File: include/sram_ctrl_pkg.sv
// Types shared by the SRAM controller and its delay counter.
// Assumes sram_ctrl_regs.svh is on the include path.
`include "sram_ctrl_regs.svh"

package sram_ctrl_pkg;

    typedef enum logic [`STATE_W-1:0] {
        ST_IDLE      = 4'h0,
        ST_RD_SETUP  = 4'h1,
        ST_RD_ACCESS = 4'h2,
        ST_RECOVER   = 4'h3,
        ST_WR_SETUP  = 4'h4,
        ST_WR_PULSE  = 4'h5,
        ST_WR_END    = 4'h6,
        ST_RETAIN    = 4'h7
    } state_e;

    typedef struct packed {
        state_e              st;
        logic [`ADDR_W-1:0]  addr;
        logic [`DATA_W-1:0]  wdata;
        logic [`DATA_W-1:0]  rdata;
        logic [`LANE_W-1:0]  lanes_n;
        logic                sel_n;
        logic                sel_h;
        logic                strobe_n;
        logic                gate_n;
        logic                dq_oe;
        logic                rsp_valid;
        logic                ready;
        logic                retaining;
    } ctrl_s;

    typedef struct packed {
        logic [`CNT_W-1:0]   count;
    } cnt_s;

endpackage : sram_ctrl_pkg

// File: design/delay_count.sv
// Down-counter used to time the SRAM pin phases.
// Assumes the owner loads it on the edge that enters a timed phase.
`include "sram_ctrl_regs.svh"

module delay_count (
    input  wire logic               CLK,
    input  wire logic               RST_N,
    input  wire logic               CE,
    input  wire logic               load,
    input  wire logic [`CNT_W-1:0]  load_val,
    output logic                    zero
);
    sram_ctrl_pkg::cnt_s c_q;
    sram_ctrl_pkg::cnt_s c_d;

    // Load wins; otherwise count down and stop at zero
    always_comb begin
        c_d = c_q;
        if (load) begin
            c_d.count = load_val;
        end else if (c_q.count != '0) begin
            c_d.count = c_q.count - `CNT_W'(1);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            c_q <= '0;
        end else if (CE) begin
            c_q <= c_d;
        end
    end

    assign zero = (c_q.count == '0);

endmodule : delay_count

// File: bench/sram_dev.sv
// Behavioural model of the asynchronous 2M x 8 memory on the pins.
// Assumes the bench resolves the shared data wire and feeds it to bus.
module sram_dev (
    input  wire logic [20:0] addr,
    input  wire logic        sel_n,
    input  wire logic        sel_h,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic        ub_n,
    input  wire logic        lb_n,
    input  wire logic [7:0]  bus,
    output logic [7:0]       dq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [logic [20:0]];
    logic [7:0] word;
    logic [7:0] late;
    logic       sel;
    logic       wr;
    logic       rd;
    logic       wr_was = 1'b0;
    // Selection and the write and read windows
    assign sel = !sel_n && sel_h;
    assign wr  = sel && !we_n && !(ub_n && lb_n);
    assign rd  = sel && we_n && !oe_n;
    // Write lands when any qualifier leaves the overlap; the same process refreshes the
    // array word, so a read of the address just written never races the store
    always @(addr or wr) begin
        if (wr_was === 1'b1 && wr === 1'b0)
            mem[addr] = bus;
        wr_was = wr;
        word   = mem.exists(addr) ? mem[addr] : 8'h00;
    end
    // Old data kept for the full access time, then the new word
    assign #10 late = word;
    // Released pins show the inverse, so a stale sample never matches
    assign #2 dq = rd ? late : ~late;
endmodule : sram_dev

// File: bench/sram_ctrl_assertions.sv
// Pin checker for the SRAM controller, bound to every sram_ctrl.
// Assumes CE stays high while the checked sequences run.
`include "sram_ctrl_regs.svh"
module sram_ctrl_assertions (
    input wire logic               CLK,
    input wire logic               RST_N,
    input wire logic               RSP_VALID,
    input wire logic [`DATA_W-1:0] RSP_RDATA,
    input wire logic               RETAINING,
    input wire logic [`ADDR_W-1:0] MEM_ADDR,
    input wire logic               PRIMARY_SELECT_N,
    input wire logic               SECONDARY_SELECT_HIGH,
    input wire logic               WRITE_STROBE_N,
    input wire logic               OUTPUT_GATE_N,
    input wire logic [`DATA_W-1:0] DQ_IN,
    input wire logic [`DATA_W-1:0] DQ_OUT,
    input wire logic               DQ_OE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // Read start and its one-cycle answer
    sequence rd_go;
        $fell(PRIMARY_SELECT_N) && WRITE_STROBE_N;
    endsequence
    sequence rd_ans;
        ##4 RSP_VALID ##1 !RSP_VALID;
    endsequence
    chk_read_answer: assert property (rd_go |-> rd_ans)
        else $error("read answer off time");
    chk_read_data: assert property (RSP_VALID |-> RSP_RDATA == $past(DQ_IN))
        else $error("read data not the sampled pins");
    chk_read_addr: assert property ($fell(PRIMARY_SELECT_N) |-> $stable(MEM_ADDR))
        else $error("address moved with select");
    chk_float_wait: assert property ($rose(OUTPUT_GATE_N) |-> (!DQ_OE)[*2])
        else $error("data driven before float");
    chk_write_qual: assert property (!WRITE_STROBE_N |-> !PRIMARY_SELECT_N && DQ_OE)
        else $error("strobe without select or data");
    chk_strobe_width: assert property ($fell(WRITE_STROBE_N) |-> (!WRITE_STROBE_N)[*3] ##1 WRITE_STROBE_N)
        else $error("strobe width wrong");
    chk_write_hold: assert property (!WRITE_STROBE_N |=> $stable(MEM_ADDR) && $stable(DQ_OUT))
        else $error("address or data moved in write");
    chk_no_clash: assert property (!OUTPUT_GATE_N |-> !DQ_OE && WRITE_STROBE_N)
        else $error("gate low while driving");
    chk_select_pair: assert property (PRIMARY_SELECT_N != SECONDARY_SELECT_HIGH)
        else $error("selects disagree");
    chk_retain_park: assert property (RETAINING |-> PRIMARY_SELECT_N && WRITE_STROBE_N && OUTPUT_GATE_N
                                      && MEM_ADDR == 0 && DQ_OE && DQ_OUT == 0)
        else $error("pins not parked");
    chk_retain_wait: assert property ($fell(RETAINING) |-> PRIMARY_SELECT_N[*3])
        else $error("access too soon after retention");
endmodule : sram_ctrl_assertions

bind sram_ctrl sram_ctrl_assertions i_sram_ctrl_assertions (.CLK, .RST_N, .RSP_VALID, .RSP_RDATA, .RETAINING,
    .MEM_ADDR, .PRIMARY_SELECT_N, .SECONDARY_SELECT_HIGH, .WRITE_STROBE_N, .OUTPUT_GATE_N, .DQ_IN, .DQ_OUT, .DQ_OE);

// File: bench/sram_ctrl_tb.sv
// Self-checking bench: controller against the memory model.
// Assumes the default 10 ns grade counts; CE drops only while parked in retention.
`include "sram_ctrl_regs.svh"
module sram_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, rv = 0, rw = 0, retain = 0, ce = 1;
    logic [20:0] ra = '0, mem_addr;
    logic [7:0]  rd_w = '0, rsp_rdata, dq_in, dq_out, dev_dq;
    logic [1:0]  rl = '0;
    logic        ready, rsp_valid, retaining, sel_n, sel_h, we_n, oe_n, ub_n, lb_n, dq_oe;
    logic [7:0]  exp_mem [logic [20:0]];
    logic [7:0]  exp_q [$];
    logic [20:0] addrs [8];
    int          err_total = 0, n_checks = 0;
    // Shared data wire: controller wins when enabled
    assign dq_in = dq_oe ? dq_out : dev_dq;
    sram_ctrl i_sram_ctrl (.CLK(clk), .RST_N(rst_n), .CE(ce), .REQ_VALID(rv), .REQ_READY(ready), .REQ_WRITE(rw),
        .REQ_ADDR(ra), .REQ_WDATA(rd_w), .REQ_LANES_N(rl), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
        .RETAIN(retain), .RETAINING(retaining), .MEM_ADDR(mem_addr), .PRIMARY_SELECT_N(sel_n),
        .SECONDARY_SELECT_HIGH(sel_h), .WRITE_STROBE_N(we_n), .OUTPUT_GATE_N(oe_n), .UPPER_LANE_ENABLE_N(ub_n),
        .LOWER_LANE_ENABLE_N(lb_n), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe));
    sram_dev i_sram_dev (.addr(mem_addr), .sel_n(sel_n), .sel_h(sel_h), .we_n(we_n), .oe_n(oe_n),
        .ub_n(ub_n), .lb_n(lb_n), .bus(dq_in), .dq(dev_dq));
    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk
    // One request; the note of the expected byte is made when it is taken
    task automatic req(input logic w, input logic [20:0] a, input logic [7:0] d, input logic [1:0] ln);
        int n;
        n = 0;
        @(negedge clk);
        rv = 1;
        rw = w;
        ra = a;
        rd_w = d;
        rl = ln;
        // Ready is settled at the falling edge; seen high there, the next rising edge takes
        while (ready !== 1'b1 && n < 60) begin
            n++;
            @(negedge clk);
        end
        chk(n < 60, "request never taken");
        if (!w)
            exp_q.push_back(exp_mem[a]);
        else if (ln != 2'h3)
            exp_mem[a] = d;
        @(negedge clk);
        rv = 0;
    endtask : req
    task automatic conclude;
        if (err_total == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    // Answer watcher takes the oldest note per answer
    always @(negedge clk) begin
        if (rsp_valid === 1'b1) begin
            chk(exp_q.size() > 0 && rsp_rdata === exp_q[0], "read data");
            if (exp_q.size() > 0)
                void'(exp_q.pop_front());
        end
    end
    // Whole run is about 1 us; a hang is cut at 20 us
    initial begin
        #20us;
        err_total++;
        conclude();
    end
    initial begin
        void'($urandom(18));
        for (int i = 0; i < 8; i++) addrs[i] = 21'($urandom);
        addrs[0] = 21'h000000;
        addrs[7] = 21'h1FFFFF;
        repeat (8) @(negedge clk);
        rst_n = 1;
        @(negedge clk);
        chk(sel_n && !sel_h && we_n && oe_n && ub_n && lb_n && !dq_oe, "idle pins");
        // Random bytes over edge and random addresses, then read back reversed
        for (int i = 0; i < 8; i++) req(1, addrs[i], 8'($urandom), 2'h0);
        for (int i = 7; i >= 0; i--) req(0, addrs[i], 8'h00, 2'h0);
        // Every lane code; all lanes off must leave the byte alone
        for (int i = 0; i < 4; i++) begin
            req(1, addrs[i], 8'($urandom), 2'(i));
            req(0, addrs[i], 8'h00, 2'($urandom));
        end
        // Retention is only entered from idle, so let the last read recover first
        @(negedge clk);
        while (ready !== 1'b1) @(negedge clk);
        retain = 1;
        repeat (4) @(negedge clk);
        chk(retaining && sel_n && !sel_h && we_n && oe_n && mem_addr === 21'h0 && dq_oe, "parked");
        // Clock enable low must freeze the parked state even though retention is dropped
        ce = 0;
        retain = 0;
        repeat (3) @(negedge clk);
        chk(retaining === 1'b1 && dq_oe === 1'b1 && sel_n === 1'b1, "not frozen by clock enable");
        ce = 1;
        req(0, addrs[7], 8'h00, 2'h0);
        repeat (20) @(negedge clk);
        chk(exp_q.size() == 0, "answers missing");
        conclude();
    end
endmodule : sram_ctrl_tb
